// ### verilog/dio_pkg.sv
/*
 * Shared constants, register map and types for the drive I/O timing layer.
 * Assumes a 50 MHz core clock and a plain single-cycle register port.
 */
package dio_pkg;
	// clock and loop timing
	localparam int CLK_MHZ        = 50;
	localparam int CUR_PERIOD_NS  = 50000;
	localparam int CUR_CYCLES     = CUR_PERIOD_NS * CLK_MHZ / 1000;
	localparam int SPD_MULT       = 2;
	localparam int POS_MULT       = 4;
	localparam int FILTER_PERIODS = 4;
	localparam int TRACK_SAMPLES  = 4;
	// power-on and enable timing
	localparam int STAGE_DELAY_US = 6000;
	localparam int BOOT_MS        = 4000;
	localparam int MAINS_LOSS_MS  = 600;
	localparam int ANALOG_LEVEL_OUT_DELAY_NS  = 85000;
	localparam int MS_CYC         = 1000 * CLK_MHZ;
	localparam int STAGE_CYC      = STAGE_DELAY_US * CLK_MHZ;
	localparam int BOOT_CYC       = BOOT_MS * MS_CYC;
	localparam int MAINS_CYC      = MAINS_LOSS_MS * MS_CYC;
	localparam int ANALOG_LEVEL_OUT_CYC       = ANALOG_LEVEL_OUT_DELAY_NS * CLK_MHZ / 1000;
	// input line roles
	localparam int DIN_COUNT   = 9;
	localparam int DIN_START   = 4;
	localparam int DIN_ENABLE  = 5;
	localparam int DIN_LIMIT0  = 6;
	localparam int DIN_LIMIT1  = 7;
	localparam int DIN_SAMPLE  = 8;
	localparam int DOUT_COUNT  = 2;
	// widths
	localparam int ADC_W   = 12;
	localparam int DAC_W   = 10;
	localparam int ANGLE_W = 16;
	localparam int LIN_W   = 28;
	localparam int LOUT_W  = 16;
	localparam int CNT_W   = LIN_W + 2;
	localparam int EMU_W   = LOUT_W + 2;
	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DOUT   = 8'h04;
	localparam logic [7:0] REG_LIN    = 8'h08;
	localparam logic [7:0] REG_LOUT   = 8'h0C;
	localparam logic [7:0] REG_IPO    = 8'h10;
	localparam logic [7:0] REG_SWAIT  = 8'h14;
	localparam logic [7:0] REG_HWAIT  = 8'h18;
	localparam logic [7:0] REG_AINF   = 8'h1C;
	localparam logic [7:0] REG_ANALOG_LEVEL_OUT   = 8'h20;
	localparam logic [7:0] REG_STAT   = 8'h24;
	localparam logic [7:0] REG_COUNT  = 8'h28;
	localparam logic [7:0] REG_SAMPLE = 8'h2C;
	localparam logic [7:0] REG_AIN    = 8'h30;
	// reset values and write clamp limits
	localparam logic [LIN_W-1:0]  LIN_RST   = 28'h0000400;
	localparam logic [LOUT_W-1:0] LOUT_RST  = 16'h0400;
	localparam logic [7:0]        IPO_RST   = 8'h04;
	localparam logic [3:0]        AINF_MIN  = 4'h1;
	localparam logic [3:0]        AINF_MAX  = 4'hC;
	localparam logic [15:0]       WAIT_MAX  = 16'h7D00;
	// link modes
	typedef enum logic [1:0] {
		LINK_QUAD  = 2'h0,
		LINK_PDIR  = 2'h1,
		LINK_EMU   = 2'h2
	} link_mode_e;
	// control register layout
	typedef struct packed {
		logic [3:0] sample_sel;
		logic [3:0] start_sel;
		logic [1:0] pad;
		link_mode_e mode;
	} ctrl_s;
	localparam logic [11:0] CTRL_RST = {4'h8, 4'h4, 2'h0, 2'h0};
	// quadrature track pair
	typedef struct packed {
		logic a;
		logic b;
	} track_s;
endpackage

// ### verilog/line_filter.sv
/*
 * One input line: three-stage synchroniser plus a run-length filter.
 * Assumes tick_i is a one-cycle pulse on core_clk_i; tie it high to
 * filter on every clock.
 */
module line_filter import dio_pkg::*; #(
	parameter int RUN = 4
) (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	// line
	input  wire logic pin_i,
	input  wire logic tick_i,
	output logic      fast_o,
	output logic      level_o
);
	logic       s1;
	logic       s2;
	logic       s3;
	logic [3:0] run;
	wire        differs = (fast_o != level_o);
	wire        run_done = (run == 4'(RUN - 1));

	// synchroniser; a change counts only once stages two and three agree
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			s1     <= 1'b0;
			s2     <= 1'b0;
			s3     <= 1'b0;
			fast_o <= 1'b0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				fast_o <= s3;
		end
	end

	// level moves after RUN consecutive differing samples
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			run     <= 4'h0;
			level_o <= 1'b0;
		end else if (tick_i) begin
			run <= (differs && !run_done) ? run + 4'h1 : 4'h0;
			if (differs && run_done)
				level_o <= fast_o;
		end
	end
endmodule

// ### verilog/drive_io_pulse_interface.sv
/*
 * Digital I/O timing layer: loop ticks, input filters, positioning start,
 * track link (quadrature in, pulse/direction in, encoder emulation out),
 * switched outputs, enable sequencing and analog filter timing.
 * Assumes a 50 MHz core clock and a register master that never waits.
 */
module drive_io_pulse_interface import dio_pkg::*; #(
	parameter int STAGE_CYCLES = STAGE_CYC,
	parameter int MS_CYCLES    = MS_CYC,
	parameter int BOOT_CYCLES  = BOOT_CYC,
	parameter int MAINS_CYCLES = MAINS_CYC,
	parameter int ANALOG_LEVEL_OUT_CYCLES  = ANALOG_LEVEL_OUT_CYC
) (
	// clock and reset
	input  wire logic                  core_clk_i,
	input  wire logic                  sys_rst_i,
	// register port
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [31:0]           reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic      [31:0]           reg_rdata_o,
	// digital inputs and outputs
	input  wire logic [DIN_COUNT-1:0]  din_i,
	output logic      [DOUT_COUNT-1:0] dout_o,
	// track link
	input  wire track_s                track_i,
	output track_s                     track_o,
	output logic                       track_oe_n_o,
	// encoder and analog
	input  wire logic [ANGLE_W-1:0]    angle_i,
	input  wire logic [ADC_W-1:0]      analog_level_in_i,
	output logic      [DAC_W-1:0]      analog_level_out_o,
	// drive status
	input  wire logic                  mains_ok_i,
	output logic                       control_ready_o,
	output logic                       stage_active_o,
	output logic                       motion_allowed_o,
	output logic                       mains_lost_o,
	output logic      [1:0]            limit_o,
	output logic                       start_o,
	output logic      [3:0]            pos_set_o
);
	typedef enum logic [4:0] {
		ST_OFF   = 5'b00001,
		ST_RAMP  = 5'b00010,
		ST_SWAIT = 5'b00100,
		ST_RUN   = 5'b01000,
		ST_HALT  = 5'b10000
	} pwr_state_e;

	ctrl_s                ctrl;
	logic [DOUT_COUNT-1:0] dout_cmd, dout_stage;
	logic [LIN_W-1:0]     lines_in;
	logic [LOUT_W-1:0]    lines_out;
	logic [7:0]           ipo_mult;
	logic [15:0]          swait_ms, hwait_ms;
	logic [3:0]           ain_shift;
	logic [DAC_W-1:0]     analog_level_out_cmd, analog_level_out_hold;
	logic [31:0]          boot_cnt, main_cnt, ms_cyc, mains_cnt, analog_level_out_cnt;
	logic [15:0]          ms_cnt;
	logic [11:0]          cur_cnt;
	logic [2:0]           sub_cnt;
	logic [7:0]           ipo_cnt;
	logic                 cur_tick, spd_tick, pos_tick, ipo_tick;
	logic [DIN_COUNT-1:0] din_fast, din_level;
	track_s               trk_fast, trk_lvl, trk_prev;
	logic [CNT_W-1:0]     count, sample_pos;
	logic                 samp_prev, start_prev, start_pend;
	logic [EMU_W-1:0]     emu_pos;
	logic [ADC_W+11:0]    ain_acc;
	pwr_state_e           pwr;

	// loop ticks from one base counter, running once boot is done
	wire cur_wrap = (cur_cnt == 12'(CUR_CYCLES - 1));
	wire boot_done = (boot_cnt == 32'(BOOT_CYCLES - 1));
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			boot_cnt        <= 32'h0;
			control_ready_o <= 1'b0;
			cur_cnt         <= 12'h0;
			sub_cnt         <= 3'h0;
			ipo_cnt         <= 8'h0;
			cur_tick        <= 1'b0;
			spd_tick        <= 1'b0;
			pos_tick        <= 1'b0;
			ipo_tick        <= 1'b0;
		end else begin
			if (!control_ready_o) begin
				boot_cnt        <= boot_cnt + 32'h1;
				control_ready_o <= boot_done;
			end
			cur_cnt  <= (cur_wrap || !control_ready_o) ? 12'h0 : cur_cnt + 12'h1;
			cur_tick <= cur_wrap;
			spd_tick <= cur_wrap && (sub_cnt[0] == 1'b1);
			pos_tick <= cur_wrap && (sub_cnt == 3'(POS_MULT - 1));
			ipo_tick <= cur_wrap && (sub_cnt == 3'(POS_MULT - 1)) && (ipo_cnt >= ipo_mult - 8'h1);
			if (cur_wrap) begin
				sub_cnt <= (sub_cnt == 3'(POS_MULT - 1)) ? 3'h0 : sub_cnt + 3'h1;
				if (sub_cnt == 3'(POS_MULT - 1))
					ipo_cnt <= (ipo_cnt >= ipo_mult - 8'h1) ? 8'h0 : ipo_cnt + 8'h1;
			end
		end
	end

	// digital input filters, evaluated once per position period
	for (genvar i = 0; i < DIN_COUNT; i++) begin : g_din
		line_filter #(.RUN(FILTER_PERIODS)) u_din (
			.core_clk_i (core_clk_i),
			.sys_rst_i  (sys_rst_i),
			.pin_i      (din_i[i]),
			.tick_i     (pos_tick),
			.fast_o     (din_fast[i]),
			.level_o    (din_level[i])
		);
	end

	// track inputs filtered on every clock by four-sample agreement
	line_filter #(.RUN(TRACK_SAMPLES)) u_trk_a (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.pin_i      (track_i.a),
		.tick_i     (1'b1),
		.fast_o     (trk_fast.a),
		.level_o    (trk_lvl.a)
	);
	line_filter #(.RUN(TRACK_SAMPLES)) u_trk_b (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.pin_i      (track_i.b),
		.tick_i     (1'b1),
		.fast_o     (trk_fast.b),
		.level_o    (trk_lvl.b)
	);

	// role selection; lines 5 to 7 keep their fixed roles
	wire start_ok  = (ctrl.start_sel < 4'(DIN_COUNT)) &&
	                 !(ctrl.start_sel >= 4'(DIN_ENABLE) && ctrl.start_sel <= 4'(DIN_LIMIT1));
	wire sample_ok = (ctrl.sample_sel < 4'(DIN_COUNT)) &&
	                 !(ctrl.sample_sel >= 4'(DIN_ENABLE) && ctrl.sample_sel <= 4'(DIN_LIMIT1));
	wire start_line  = start_ok ? din_level[ctrl.start_sel] : din_level[DIN_START];
	wire sample_line = sample_ok ? din_fast[ctrl.sample_sel] : din_fast[DIN_SAMPLE];
	wire enable_line = din_level[DIN_ENABLE] && control_ready_o;
	assign limit_o   = {din_level[DIN_LIMIT1], din_level[DIN_LIMIT0]};

	// track decode: quadrature direction or step/direction
	wire [CNT_W-1:0] cnt_max = {lines_in, 2'b00} - CNT_W'(1);
	wire a_chg     = trk_lvl.a ^ trk_prev.a;
	wire b_chg     = trk_lvl.b ^ trk_prev.b;
	wire quad_step = (a_chg ^ b_chg) && (ctrl.mode == LINK_QUAD);
	wire quad_up   = trk_prev.b ^ trk_lvl.a; // A leads B counts up
	wire pd_step   = (ctrl.mode == LINK_PDIR) && trk_lvl.a && !trk_prev.a;
	wire step      = quad_step || pd_step;
	wire step_up   = (ctrl.mode == LINK_PDIR) ? trk_lvl.b : quad_up;
	wire [CNT_W-1:0] next_count = step_up ? ((count >= cnt_max) ? '0 : count + CNT_W'(1)) :
	                              ((count == '0) ? cnt_max : count - CNT_W'(1));
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			trk_prev   <= '0;
			count      <= '0;
			samp_prev  <= 1'b0;
			sample_pos <= '0;
		end else begin
			trk_prev  <= trk_lvl;
			samp_prev <= sample_line;
			if (step)
				count <= next_count;
			if (sample_line && !samp_prev)
				sample_pos <= count;
		end
	end

	// emulation: walk one quarter line per clock toward the angle target
	wire [EMU_W-1:0]   emu_mod  = {lines_out, 2'b00};
	wire [33:0]        emu_prod = 34'(angle_i) * 34'(emu_mod);
	wire [EMU_W-1:0]   emu_tgt  = emu_prod[EMU_W+ANGLE_W-1:ANGLE_W];
	wire [EMU_W:0]     emu_diff = (emu_tgt >= emu_pos) ? {1'b0, emu_tgt - emu_pos} :
	                              {1'b0, emu_tgt} + {1'b0, emu_mod} - {1'b0, emu_pos};
	wire               emu_up   = emu_diff < {2'b00, emu_mod[EMU_W-1:1]};
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			emu_pos <= '0;
			track_o <= '0;
		end else begin
			// bursts follow angle jumps; edge spacing carries no speed
			if (ctrl.mode == LINK_EMU && emu_diff != '0) begin
				if (emu_up)
					emu_pos <= (emu_pos >= emu_mod - EMU_W'(1)) ? '0 : emu_pos + EMU_W'(1);
				else
					emu_pos <= (emu_pos == '0) ? emu_mod - EMU_W'(1) : emu_pos - EMU_W'(1);
			end
			track_o.a <= emu_pos[1] ^ emu_pos[0];
			track_o.b <= emu_pos[1];
		end
	end
	assign track_oe_n_o = (ctrl.mode != LINK_EMU);

	// start waits for the next interpolation tick
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			start_prev <= 1'b0;
			start_pend <= 1'b0;
			start_o    <= 1'b0;
			pos_set_o  <= 4'h0;
		end else begin
			start_o <= 1'b0;
			if (pos_tick)
				start_prev <= start_line;
			if (!motion_allowed_o)
				start_pend <= 1'b0;
			else if (ipo_tick && (start_pend || (pos_tick && start_line && !start_prev))) begin
				start_pend <= 1'b0;
				start_o    <= 1'b1;
				pos_set_o  <= din_level[3:0];
			end else if (pos_tick && start_line && !start_prev)
				start_pend <= 1'b1;
		end
	end

	// switched outputs: latched on one position tick, driven on the next
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			dout_stage <= '0;
			dout_o     <= '0;
		end else if (pos_tick) begin
			dout_stage <= dout_cmd;
			dout_o     <= dout_stage;
		end
	end

	// enable sequencing: stage ramp, start wait, run, halt wait
	wire ms_wrap   = (ms_cyc == 32'(MS_CYCLES - 1));
	wire stage_due = (main_cnt == 32'(STAGE_CYCLES - 1));
	wire sw_done   = (ms_cnt >= swait_ms);
	wire hw_done   = (ms_cnt >= hwait_ms);
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			pwr      <= ST_OFF;
			main_cnt <= 32'h0;
			ms_cyc   <= 32'h0;
			ms_cnt   <= 16'h0;
		end else begin
			main_cnt <= main_cnt + 32'h1;
			ms_cyc   <= ms_wrap ? 32'h0 : ms_cyc + 32'h1;
			if (ms_wrap)
				ms_cnt <= ms_cnt + 16'h1;
			unique case (pwr)
				ST_OFF: begin
					main_cnt <= 32'h0;
					if (enable_line)
						pwr <= ST_RAMP;
				end
				ST_RAMP: begin
					ms_cyc <= 32'h0;
					ms_cnt <= 16'h0;
					if (!enable_line)
						pwr <= ST_OFF;
					else if (stage_due)
						pwr <= ST_SWAIT;
				end
				ST_SWAIT: begin
					if (!enable_line) begin
						pwr    <= ST_HALT;
						ms_cyc <= 32'h0;
						ms_cnt <= 16'h0;
					end else if (sw_done)
						pwr <= ST_RUN;
				end
				ST_RUN: begin
					ms_cyc <= 32'h0;
					ms_cnt <= 16'h0;
					if (!enable_line)
						pwr <= ST_HALT;
				end
				ST_HALT: begin
					if (hw_done)
						pwr <= ST_OFF;
				end
			endcase
		end
	end
	assign stage_active_o   = (pwr == ST_SWAIT) || (pwr == ST_RUN) || (pwr == ST_HALT);
	assign motion_allowed_o = (pwr == ST_RUN);

	// mains watchdog and analog filters
	wire analog_level_out_due = (analog_level_out_cnt == 32'(ANALOG_LEVEL_OUT_CYCLES - 1));
	wire [ADC_W+11:0] ain_in = {analog_level_in_i, 12'h000};
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			mains_cnt          <= 32'h0;
			mains_lost_o       <= 1'b0;
			ain_acc            <= '0;
			analog_level_out_hold          <= '0;
			analog_level_out_cnt           <= 32'h0;
			analog_level_out_o <= '0;
		end else begin
			mains_cnt <= mains_ok_i ? 32'h0 : (mains_lost_o ? mains_cnt : mains_cnt + 32'h1);
			mains_lost_o <= !mains_ok_i && (mains_lost_o || mains_cnt == 32'(MAINS_CYCLES - 1));
			if (cur_tick)
				ain_acc <= ain_acc + ((ain_in >>> ain_shift) - (ain_acc >>> ain_shift));
			if (analog_level_out_cnt != 32'h0)
				analog_level_out_cnt <= analog_level_out_due ? 32'h0 : analog_level_out_cnt + 32'h1;
			else if (cur_tick) begin
				analog_level_out_hold <= analog_level_out_cmd;
				analog_level_out_cnt  <= 32'h1;
			end
			if (analog_level_out_due)
				analog_level_out_o <= analog_level_out_hold;
		end
	end

	// register writes; filter shift clamped to its legal span
	wire [3:0] ainf_w = (reg_wdata_i[3:0] < AINF_MIN) ? AINF_MIN :
	                    (reg_wdata_i[3:0] > AINF_MAX) ? AINF_MAX : reg_wdata_i[3:0];
	wire [15:0] wait_w = (reg_wdata_i[15:0] > WAIT_MAX) ? WAIT_MAX : reg_wdata_i[15:0];
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ctrl      <= CTRL_RST;
			dout_cmd  <= '0;
			lines_in  <= LIN_RST;
			lines_out <= LOUT_RST;
			ipo_mult  <= IPO_RST;
			swait_ms  <= 16'h0;
			hwait_ms  <= 16'h0;
			ain_shift <= AINF_MIN;
			analog_level_out_cmd  <= '0;
		end else if (reg_wr_i) begin
			unique case (reg_addr_i)
				REG_CTRL:  ctrl      <= reg_wdata_i[11:0];
				REG_DOUT:  dout_cmd  <= reg_wdata_i[DOUT_COUNT-1:0];
				REG_LIN:   lines_in  <= (reg_wdata_i[LIN_W-1:0] == '0) ? LIN_RST : reg_wdata_i[LIN_W-1:0];
				REG_LOUT:  lines_out <= (reg_wdata_i[LOUT_W-1:0] == '0) ? LOUT_RST : reg_wdata_i[LOUT_W-1:0];
				REG_IPO:   ipo_mult  <= (reg_wdata_i[7:0] == 8'h0) ? IPO_RST : reg_wdata_i[7:0];
				REG_SWAIT: swait_ms  <= wait_w;
				REG_HWAIT: hwait_ms  <= wait_w;
				REG_AINF:  ain_shift <= ainf_w;
				REG_ANALOG_LEVEL_OUT:  analog_level_out_cmd  <= reg_wdata_i[DAC_W-1:0];
				default:   ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	wire [31:0] stat_w = {13'h0, limit_o, mains_lost_o, motion_allowed_o, stage_active_o,
	                      control_ready_o, pos_set_o, din_level};
	wire [31:0] rd_mux =
		(reg_addr_i == REG_CTRL)   ? {20'h0, ctrl} :
		(reg_addr_i == REG_DOUT)   ? {30'h0, dout_cmd} :
		(reg_addr_i == REG_LIN)    ? {4'h0, lines_in} :
		(reg_addr_i == REG_LOUT)   ? {16'h0, lines_out} :
		(reg_addr_i == REG_IPO)    ? {24'h0, ipo_mult} :
		(reg_addr_i == REG_SWAIT)  ? {16'h0, swait_ms} :
		(reg_addr_i == REG_HWAIT)  ? {16'h0, hwait_ms} :
		(reg_addr_i == REG_AINF)   ? {28'h0, ain_shift} :
		(reg_addr_i == REG_ANALOG_LEVEL_OUT)   ? {22'h0, analog_level_out_cmd} :
		(reg_addr_i == REG_STAT)   ? stat_w :
		(reg_addr_i == REG_COUNT)  ? {2'h0, count} :
		(reg_addr_i == REG_SAMPLE) ? {2'h0, sample_pos} :
		(reg_addr_i == REG_AIN)    ? {20'h0, ain_acc[ADC_W+11:12]} : 32'h0;
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i)
			reg_rdata_o <= 32'h0;
		else
			reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0;
	end
endmodule

// ### verif/dio_far_end.sv
/* Far-end model: stepper board or quadrature source, and an edge-counting receiver.
   Assumes the bench resolves the shared pins and pulses step_i for one cycle. */
module dio_far_end import dio_pkg::*; (
	// clock and reset
	input  wire logic   core_clk_i,
	input  wire logic   sys_rst_i,
	// step command
	input  wire logic   step_i,
	input  wire logic   dir_i,
	input  wire logic   pdir_i,
	// pins
	input  wire track_s wire_i,
	output track_s      drv_o,
	output logic [15:0] cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] ph;
	logic [3:0] pul;
	logic       dir_q;
	logic [1:0] seen;
	wire  [1:0] idx = {wire_i.b, wire_i.a ^ wire_i.b};
	// a pulse rises six cycles after b settles, so direction has setup
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			ph <= 2'h0;
			pul <= 4'h0;
			dir_q <= 1'b0;
		end else if (step_i) begin
			ph <= dir_i ? ph + 2'h1 : ph - 2'h1;
			pul <= 4'hC;
			dir_q <= dir_i;
		end else if (pul != 4'h0) begin
			pul <= pul - 4'h1;
		end
	end
	// step on a, direction on b, else gray phases
	assign drv_o = pdir_i ? {(pul != 4'h0) && (pul < 4'h7), dir_q} : {ph[1] ^ ph[0], ph[1]};
	// counts edges only, never edge spacing: bursts are fine
	always_ff @(posedge core_clk_i) begin
		seen <= sys_rst_i ? 2'h0 : idx;
		if (sys_rst_i) cnt_o <= 16'h0;
		else if (idx == seen + 2'h1) cnt_o <= cnt_o + 16'h1;
		else if (idx == seen - 2'h1) cnt_o <= cnt_o - 16'h1;
	end
endmodule

// ### verif/drive_io_pulse_interface_sva.sv
/* Checker for the drive I/O timing layer, bound to its top module.
   Assumes one clock domain and the cycle parameters handed on by the bind. */
module drive_io_pulse_interface_sva import dio_pkg::*; #(
	parameter int STAGE_CYCLES = STAGE_CYC,
	parameter int BOOT_CYCLES  = BOOT_CYC,
	parameter int MAINS_CYCLES = MAINS_CYC
) (
	input wire logic                  core_clk_i,
	input wire logic                  sys_rst_i,
	input wire logic [7:0]            reg_addr_i,
	input wire logic [31:0]           reg_wdata_i,
	input wire logic                  reg_wr_i,
	input wire logic                  reg_rd_i,
	input wire logic [31:0]           reg_rdata_o,
	input wire logic [DIN_COUNT-1:0]  din_i,
	input wire logic [DOUT_COUNT-1:0] dout_o,
	input wire logic                  track_oe_n_o,
	input wire logic                  mains_ok_i,
	input wire logic                  control_ready_o,
	input wire logic                  stage_active_o,
	input wire logic                  motion_allowed_o,
	input wire logic                  mains_lost_o,
	input wire logic [1:0]            limit_o,
	input wire logic                  start_o,
	input wire logic [3:0]            pos_set_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int POS_CYC = CUR_CYCLES * POS_MULT;
	logic [31:0] up_cnt, low_cnt, en_cnt, lim_age, dout_age;
	logic [1:0]  mode_q;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	function automatic logic [31:0] inc(input logic [31:0] v);
		return (&v) ? v : v + 32'h1;
	endfunction
	// saturating ages, so long runs never wrap back under a bound
	always_ff @(posedge core_clk_i) begin
		up_cnt <= sys_rst_i ? '0 : inc(up_cnt);
		low_cnt <= (sys_rst_i || mains_ok_i) ? '0 : inc(low_cnt);
		en_cnt <= (sys_rst_i || !din_i[DIN_ENABLE]) ? '0 : inc(en_cnt);
		lim_age <= (sys_rst_i || $changed(din_i[7:6])) ? '0 : inc(lim_age);
		dout_age <= (sys_rst_i || (reg_wr_i && reg_addr_i == REG_DOUT)) ? '0 : inc(dout_age);
	end
	// mirror of the link mode field
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) mode_q <= LINK_QUAD;
		else if (reg_wr_i && reg_addr_i == REG_CTRL) mode_q <= reg_wdata_i[1:0];
	end
	chk_read_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
		else $error("read data not zero outside read cycle");
	chk_pin_direction: assert property (track_oe_n_o == (mode_q != LINK_EMU))
		else $error("track pin direction does not follow mode");
	chk_dout_delay: assert property ($changed(dout_o) |-> dout_age >= POS_CYC)
		else $error("output changed within one position period of write");
	chk_start_pulse: assert property (start_o |=> !start_o)
		else $error("start pulse longer than one cycle");
	chk_start_gated: assert property (start_o |-> $past(motion_allowed_o))
		else $error("start while motion held off");
	chk_motion_stage: assert property (motion_allowed_o |-> stage_active_o)
		else $error("motion allowed without active stage");
	chk_stage_latency: assert property ($rose(stage_active_o) |-> en_cnt > STAGE_CYCLES)
		else $error("stage active too soon after enable");
	chk_boot_bound: assert property (up_cnt > BOOT_CYCLES + 1 |-> control_ready_o)
		else $error("control not ready after boot time");
	chk_mains_set: assert property (low_cnt > MAINS_CYCLES + 1 |-> mains_lost_o)
		else $error("mains loss not flagged");
	chk_mains_early: assert property (low_cnt < MAINS_CYCLES - 1 |-> !mains_lost_o)
		else $error("mains loss flagged too early");
	chk_limit_filter: assert property ($changed(limit_o) |-> lim_age >= 3 * POS_CYC)
		else $error("limit changed before filter time");
	chk_set_with_start: assert property ($changed(pos_set_o) |-> start_o)
		else $error("position set changed without start");
	cov_start: cover property (start_o);
	cov_stage: cover property ($rose(stage_active_o));
	cov_mains: cover property ($rose(mains_lost_o));
	cov_emu: cover property ($fell(track_oe_n_o));
endmodule
bind drive_io_pulse_interface drive_io_pulse_interface_sva #(.STAGE_CYCLES(STAGE_CYCLES),
	.BOOT_CYCLES(BOOT_CYCLES), .MAINS_CYCLES(MAINS_CYCLES)) sva (.core_clk_i, .sys_rst_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .din_i, .dout_o,
	.track_oe_n_o, .mains_ok_i, .control_ready_o, .stage_active_o, .motion_allowed_o,
	.mains_lost_o, .limit_o, .start_o, .pos_set_o);

// ### verif/drive_io_pulse_interface_tb.sv
/* Self-checking bench: registers, track link in all modes, enable and start timing.
   Assumes the checker is bound and the far-end model drives the released pins. */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module drive_io_pulse_interface_tb import dio_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, mains = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, c0, c1;
	logic [8:0] din = 9'h000;
	logic [15:0] angle = 16'h0000, r, fcnt, base;
	logic [11:0] analog_level_in = 12'h000;
	logic [9:0] analog_level_out;
	logic [1:0] dout, lim;
	logic [3:0] pset;
	logic oe_n, ready, stage, motion, lost, start, step = 1'b0, dir = 1'b0, pdir = 1'b0;
	track_s trk_in, trk_out, far_drv;
	logic [16:0] lf = 17'h11860;
	int n_fail = 0, compares = 0;
	always #10 clk = ~clk;
	// far side drives only while the block has released the pins
	assign trk_in = oe_n ? far_drv : trk_out;
	drive_io_pulse_interface #(.STAGE_CYCLES(50), .MS_CYCLES(10), .BOOT_CYCLES(20),
		.MAINS_CYCLES(30), .ANALOG_LEVEL_OUT_CYCLES(8)) uut (.core_clk_i(clk), .sys_rst_i(rst),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .din_i(din), .dout_o(dout), .track_i(trk_in),
		.track_o(trk_out), .track_oe_n_o(oe_n), .angle_i(angle), .analog_level_in_i(analog_level_in),
		.analog_level_out_o(analog_level_out), .mains_ok_i(mains), .control_ready_o(ready),
		.stage_active_o(stage), .motion_allowed_o(motion), .mains_lost_o(lost),
		.limit_o(lim), .start_o(start), .pos_set_o(pset));
	dio_far_end far (.core_clk_i(clk), .sys_rst_i(rst), .step_i(step), .dir_i(dir),
		.pdir_i(pdir), .wire_i(trk_in), .drv_o(far_drv), .cnt_o(fcnt));
	function automatic logic [15:0] rnd();
		lf = {lf[15:0], lf[16] ^ lf[13]};
		return lf[15:0];
	endfunction
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	// clamped and defaulted readback of the timing registers
	function automatic logic [31:0] exp_reg(input logic [7:0] a, input logic [15:0] w);
		case (a)
			REG_IPO: return (w == 16'h0) ? {24'h0, IPO_RST} : {16'h0, w};
			REG_AINF: return {28'h0, (w < AINF_MIN) ? AINF_MIN : (w > AINF_MAX) ? AINF_MAX : w[3:0]};
			default: return {16'h0, (w > WAIT_MAX) ? WAIT_MAX : w};
		endcase
	endfunction
	task automatic steps(input int n, input logic d);
		logic [15:0] v;
		for (int k = 0; k < n; k++) begin
			v = rnd();
			repeat (12 + v[3:0]) @(posedge clk);
			dir <= d;
			step <= 1'b1;
			@(posedge clk);
			step <= 1'b0;
		end
		repeat (30) @(posedge clk);
	endtask
	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		n_fail++;
		$display("[ERR] watchdog exp done got hang");
		finish_test();
	end
	initial begin
		static logic [7:0] regs [4] = '{REG_IPO, REG_AINF, REG_SWAIT, REG_HWAIT};
		logic [15:0] wv;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int k = 0; k < 100 && ready !== 1'b1; k++) @(posedge clk);
		rd_reg(REG_CTRL, c0); `CHK("ctrl", {20'h0, CTRL_RST}, c0)
		rd_reg(REG_LIN, c0); `CHK("lin", {4'h0, LIN_RST}, c0)
		rd_reg(REG_LOUT, c0); `CHK("lout", {16'h0, LOUT_RST}, c0)
		rd_reg(REG_STAT, c0); `CHK("stat", 32'h2000, c0)
		wr_reg(8'h3C, 32'hFFFF);
		rd_reg(8'h3C, c0); `CHK("unmapped", 32'h0, c0)
		// zero and random values through each timing register, over-range values through the two wait registers
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			foreach (regs[j]) begin
				wv = (i == 0) ? 16'h0 : (regs[j] == REG_AINF) ? {12'h0, r[3:0]} :
					(regs[j] == REG_IPO) ? {8'h0, r[7:0]} : r | {i[0], 15'h0};
				wr_reg(regs[j], {16'h0, wv});
				rd_reg(regs[j], c0); `CHK("timing reg", exp_reg(regs[j], wv), c0)
			end
		end
		$display("test registers done");
		for (int m = 0; m < 2; m++) begin
			pdir <= m[0];
			wr_reg(REG_CTRL, {20'h084, 2'h0, m[1:0]});
			repeat (30) @(posedge clk);
			rd_reg(REG_COUNT, c0);
			steps(9, 1'b1);
			steps(3, 1'b0);
			rd_reg(REG_COUNT, c1); `CHK("track count", 32'h6, (c1 - c0) & 32'hFFF)
		end
		`CHK("pins released", 1'b1, oe_n)
		wr_reg(REG_LOUT, 32'h4);
		wr_reg(REG_CTRL, {20'h084, 2'h0, LINK_EMU});
		repeat (60) @(posedge clk);
		`CHK("pins driven", 1'b0, oe_n)
		base = fcnt;
		for (int i = 0; i < 3; i++) begin
			r = rnd();
			c0 = {28'h0, angle[15:12]};
			angle <= r;
			repeat (60) @(posedge clk);
			`CHK("emulated lines", r[15:12] - c0[3:0], fcnt[3:0] - base[3:0])
			base = fcnt;
		end
		wr_reg(REG_CTRL, {20'h084, 2'h0, LINK_QUAD});
		$display("test track link done");
		wr_reg(REG_IPO, 32'h1);
		wr_reg(REG_SWAIT, 32'h1);
		wr_reg(REG_DOUT, 32'h2);
		r = rnd();
		wr_reg(REG_ANALOG_LEVEL_OUT, {22'h0, r[9:0]});
		din <= 9'h060;
		analog_level_in <= r[15:4];
		#1 `CHK("dout early", 2'h0, dout)
		repeat (5100) @(posedge clk);
		`CHK("analog_level_out", r[9:0], analog_level_out)
		repeat (5000) @(posedge clk);
		din <= 9'h07A;
		for (int k = 0; k < 70000 && start !== 1'b1; k++) @(posedge clk) #1;
		`CHK("start", 1'b1, start)
		`CHK("pos set", 4'hA, pset)
		`CHK("stage", 1'b1, stage)
		`CHK("motion", 1'b1, motion)
		`CHK("dout", 2'h2, dout)
		`CHK("limits", 2'h1, lim)
		@(posedge clk);
		mains <= 1'b0;
		repeat (40) @(posedge clk);
		`CHK("mains lost", 1'b1, lost)
		mains <= 1'b1;
		repeat (3) @(posedge clk);
		`CHK("mains back", 1'b0, lost)
		$display("test enable and start done");
		finish_test();
	end
endmodule
